/* File: hw/sol_otp_regs.vh */
// Constants for the secured OTP lock control block.
// Assumes one 20 MHz system clock and a decoded command stream.
`ifndef SOL_OTP_REGS_VH
`define SOL_OTP_REGS_VH

// ****************************************************************
// Opcodes
// ****************************************************************
`define SOL_OP_WR_SEC       8'h2F
`define SOL_OP_ENTER_OTP    8'hB1
`define SOL_OP_EXIT_OTP     8'hC1
`define SOL_OP_RD_STATUS1   8'h05
`define SOL_OP_PAGE_PROG    8'h02
`define SOL_OP_WR_STATUS1   8'h01
`define SOL_OP_WR_STATUS2   8'h31

// ****************************************************************
// Security register fields
// ****************************************************************
`define SOL_SEC_FACTORY_BIT 0
`define SOL_SEC_CUST_BIT    1

// ****************************************************************
// OTP address map
// ****************************************************************
`define SOL_OTP_SN_LAST     24'h00_000F
`define SOL_OTP_LAST        24'h00_01FF

`endif

/* File: hw/sol_otp_lock.v */
// Secured OTP lock control: decodes opcodes and the data byte of a
// write-security-register frame, holds the customer lock, OTP mode.
// Assumes the serial front end delivers whole bytes and frame ends,
// all synchronous to CLK_I; the nonvolatile lock state is restored
// through the strap inputs sampled after reset release.
`timescale 1ns/1ps
`include "sol_otp_regs.vh"

// Notes on behaviour
// - Write-security-register 2Fh needs no prior write enable.
// - 2Fh sets the customer lock bit; afterwards OTP updates refused.
// - Chip select must rise on a byte boundary, else 2Fh rejected.
// - Security bit 0 reports the factory lock.
// - OTP mode blocks main array writes; locks are permanent.
// - OTP 000-00F is serial number, 010-1FF general, 4K bits.
// - Under high voltage only status read and page program pass.
// - B1h enters OTP mode, steering reads and programs there.
// - C1h exits OTP mode back to the main array.
// - In OTP mode status and security writes are ignored.
module sol_otp_lock (
    input  wire        CLK_I,
    input  wire        RST_B_I,
    input  wire        BYTE_VALID_I,    // One byte received this cycle
    input  wire [7:0]  BYTE_I,
    input  wire        BIT_IN_BYTE_I,   // Partial byte pending
    input  wire        CS_RISE_I,       // Frame end pulse
    input  wire        ACCEL_HV_I,      // Accel pin at high voltage
    input  wire        FACTORY_LOCK_I,  // Nonvolatile strap
    input  wire        CUST_LOCK_NV_I,  // Nonvolatile strap
    input  wire [23:0] PROG_ADDR_I,     // Address of a program access
    input  wire        PROG_REQ_I,      // Program request pulse
    output reg  [7:0]  SEC_REG_O,
    output reg         OTP_MODE_O,
    output reg         OTP_PROG_EN_O,   // Program goes to OTP
    output reg         ARRAY_PROG_EN_O, // Program goes to main array
    output reg         SN_FIELD_O,      // Access in serial number field
    output reg         CMD_BLOCKED_O,   // Opcode refused
    output reg         CUST_LOCK_PGM_O  // Pulse: burn lock bit
);

    // ************************************************************
    // Reset release
    // ************************************************************
    // Reset enters at once but leaves through two flops, so no flop
    // below sees the release close to a clock edge.
    reg rst_s1_reg;
    reg rst_b_reg;
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_s1_reg <= 1'b0;
            rst_b_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_b_reg  <= rst_s1_reg;
        end
    end

    // ************************************************************
    // Frame state, one-hot
    // ************************************************************
    // IDLE waits for an opcode, DATA for the single lock byte, WAIT
    // for the frame end after it, SKIP swallows the rest of a frame.
    // A frame that is cut short falls back to IDLE at its end, unless that end comes in the same cycle as its opcode byte.
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_SKIP = 4'b0010;
    localparam [3:0] ST_DATA = 4'b0100;
    localparam [3:0] ST_WAIT = 4'b1000;

    reg [3:0] state_reg;
    reg [7:0] sec_data_reg;
    reg       factory_reg;
    reg       cust_reg;
    reg       strap_done_reg;

    // Opcode allowed while the accel pin is high
    function hv_allowed;
        input [7:0] op;
        begin
            hv_allowed = (op == `SOL_OP_RD_STATUS1) ||
                         (op == `SOL_OP_PAGE_PROG);
        end
    endfunction

    // Register writes that OTP mode ignores
    function otp_ignored;
        input [7:0] op;
        begin
            otp_ignored = (op == `SOL_OP_WR_STATUS1) ||
                          (op == `SOL_OP_WR_STATUS2) ||
                          (op == `SOL_OP_WR_SEC);
        end
    endfunction

    // Security word as read back; the reserved upper bits read 0
    function [7:0] sec_word;
        input fac;
        input cust;
        begin
            sec_word                       = 8'h00;
            sec_word[`SOL_SEC_FACTORY_BIT] = fac;
            sec_word[`SOL_SEC_CUST_BIT]    = cust;
        end
    endfunction

    // Address falls at or below the last address of a region
    function in_region;
        input [23:0] addr;
        input [23:0] last;
        begin
            in_region = (addr <= last);
        end
    endfunction

    // An opcode is the first byte of a frame; both refusal lists fold in
    wire locked = factory_reg | cust_reg;
    wire is_op  = BYTE_VALID_I && (state_reg == ST_IDLE);
    wire op_ok  = !(ACCEL_HV_I && !hv_allowed(BYTE_I)) &&
                  !(OTP_MODE_O && otp_ignored(BYTE_I));

    // ************************************************************
    // Command decode and lock update
    // ************************************************************
    // Lock bits only ever set, so a lock once held is permanent.
    always @(posedge CLK_I or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            state_reg       <= ST_IDLE;
            sec_data_reg    <= 8'h00;
            factory_reg     <= 1'b0;
            cust_reg        <= 1'b0;
            strap_done_reg  <= 1'b0;
            OTP_MODE_O      <= 1'b0;
            CMD_BLOCKED_O   <= 1'b0;
            CUST_LOCK_PGM_O <= 1'b0;
        end else begin
            CMD_BLOCKED_O   <= 1'b0;
            CUST_LOCK_PGM_O <= 1'b0;
            // Straps caught once after release, never lowered later
            if (!strap_done_reg) begin
                strap_done_reg <= 1'b1;
                factory_reg    <= FACTORY_LOCK_I;
                cust_reg       <= CUST_LOCK_NV_I;
            end
            case (state_reg)
                ST_IDLE: begin
                    // A refused opcode is flagged once, its frame dropped
                    if (is_op && !op_ok) begin
                        CMD_BLOCKED_O <= 1'b1;
                        state_reg     <= ST_SKIP;
                    end else if (is_op) begin
                        // No write-enable latch is consulted here
                        if (BYTE_I == `SOL_OP_WR_SEC) begin
                            state_reg <= ST_DATA;
                        end else if (BYTE_I == `SOL_OP_ENTER_OTP) begin
                            OTP_MODE_O <= 1'b1;
                            state_reg  <= ST_SKIP;
                        end else if (BYTE_I == `SOL_OP_EXIT_OTP) begin
                            OTP_MODE_O <= 1'b0;
                            state_reg  <= ST_SKIP;
                        end else begin
                            state_reg <= ST_SKIP;
                        end
                    end
                end
                ST_DATA: begin
                    // Frame ended before the lock byte: nothing changes
                    if (CS_RISE_I) begin
                        state_reg <= ST_IDLE;
                    end else if (BYTE_VALID_I) begin
                        sec_data_reg <= BYTE_I;
                        state_reg    <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Any further bit breaks the byte boundary
                    if (CS_RISE_I) begin
                        state_reg <= ST_IDLE;
                        if (!BIT_IN_BYTE_I && !cust_reg &&
                            sec_data_reg[`SOL_SEC_CUST_BIT]) begin
                            cust_reg        <= 1'b1;
                            CUST_LOCK_PGM_O <= 1'b1;
                        end
                    end else if (BYTE_VALID_I) begin
                        state_reg <= ST_SKIP;
                    end
                end
                ST_SKIP: begin
                    if (CS_RISE_I) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Program routing and status outputs
    // ************************************************************
    // Registered so every output comes from a flip-flop. The security
    // word trails the lock flops by a cycle; the program gate reads the
    // flops too, so a fresh lock blocks programs in that same cycle.
    always @(posedge CLK_I or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            SEC_REG_O       <= 8'h00;
            OTP_PROG_EN_O   <= 1'b0;
            ARRAY_PROG_EN_O <= 1'b0;
            SN_FIELD_O      <= 1'b0;
        end else begin
            SEC_REG_O       <= sec_word(factory_reg, cust_reg);
            // OTP program only in range and unlocked
            OTP_PROG_EN_O   <= PROG_REQ_I && OTP_MODE_O && !locked &&
                               in_region(PROG_ADDR_I, `SOL_OTP_LAST);
            ARRAY_PROG_EN_O <= PROG_REQ_I && !OTP_MODE_O;
            SN_FIELD_O      <= OTP_MODE_O &&
                               in_region(PROG_ADDR_I, `SOL_OTP_SN_LAST);
        end
    end

endmodule // sol_otp_lock

/* File: tb/sol_host_model.sv */
// Host model: opcode frames and program requests for the lock block.
// Assumes the bench calls its tasks; it drives on falling edges.
`timescale 1ns/1ps
module sol_host_model (
    input  wire        clk_i,
    output reg         bv_o   = 1'b0,
    output reg         bip_o  = 1'b0,
    output reg         cs_o   = 1'b0,
    output reg         req_o  = 1'b0,
    output reg  [7:0]  byte_o = 8'h00,
    output reg  [23:0] addr_o = 24'hFF_FFFF
);
    // Opcode, n data bytes, then frame end; cut leaves bits over
    task frame(input [7:0] op, input integer n, input [7:0] d, input cut);
        integer i;
        begin
            for (i = 0; i <= n; i = i + 1) begin
                @(negedge clk_i);
                bv_o = 1'b1;
                byte_o = (i == 0) ? op : d;
            end
            @(negedge clk_i);
            bv_o = 1'b0;
            byte_o = ~byte_o;  // Released bus keeps no stale byte
            bip_o = cut;
            cs_o = 1'b1;
            @(negedge clk_i);
            {cs_o, bip_o} = 2'b00;
        end
    endtask
    // One program request; address dropped once taken
    task prog(input [23:0] a);
        begin
            @(negedge clk_i);
            {addr_o, req_o} = {a, 1'b1};
            @(negedge clk_i);
            req_o = 1'b0;
            @(negedge clk_i);
            addr_o = ~a;
        end
    endtask
endmodule // sol_host_model

/* File: tb/sol_otp_lock_assertions.sv */
// Checker bound to the OTP lock block; sees its ports only.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`include "sol_otp_regs.vh"
module sol_otp_lock_chk (
    input wire        CLK_I,
    input wire        RST_B_I,
    input wire        BYTE_VALID_I,
    input wire        CS_RISE_I,
    input wire        ACCEL_HV_I,
    input wire        OTP_MODE_O,
    input wire        OTP_PROG_EN_O,
    input wire        ARRAY_PROG_EN_O,
    input wire        CMD_BLOCKED_O,
    input wire        CUST_LOCK_PGM_O,
    input wire [7:0]  BYTE_I,
    input wire [7:0]  SEC_REG_O,
    input wire [23:0] PROG_ADDR_I
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    reg  first_reg;  // Next byte opens a frame
    wire op = BYTE_VALID_I && first_reg && !ACCEL_HV_I;
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I)
            first_reg <= 1'b1;
        else if (CS_RISE_I || BYTE_VALID_I)
            first_reg <= CS_RISE_I;
    end
    a_pgm_cause: assert property (
        CUST_LOCK_PGM_O |-> $past(CS_RISE_I)) else $error("stray lock");
    a_lock_sets: assert property (
        CUST_LOCK_PGM_O |=> SEC_REG_O[1]) else $error("lock not set");
    a_lock_holds: assert property (
        SEC_REG_O[1] |=> SEC_REG_O[1]) else $error("lock cleared");
    a_array_shut: assert property (
        ARRAY_PROG_EN_O |-> !$past(OTP_MODE_O)) else $error("array write");
    a_otp_gate: assert property (
        OTP_PROG_EN_O |-> $past(PROG_ADDR_I) <= `SOL_OTP_LAST
        && ($past(SEC_REG_O) & 8'h03) == 8'h00) else $error("OTP write");
    a_otp_enter: assert property (
        op && BYTE_I == `SOL_OP_ENTER_OTP |=> OTP_MODE_O)
        else $error("no entry");
    a_otp_exit: assert property (
        op && BYTE_I == `SOL_OP_EXIT_OTP |=> !OTP_MODE_O)
        else $error("no exit");
    a_hv_refuse: assert property (
        BYTE_VALID_I && first_reg && ACCEL_HV_I &&
        BYTE_I != `SOL_OP_RD_STATUS1 && BYTE_I != `SOL_OP_PAGE_PROG
        |=> CMD_BLOCKED_O) else $error("passed");
    a_otp_ignore: assert property (
        op && OTP_MODE_O && (BYTE_I == `SOL_OP_WR_STATUS1 ||
        BYTE_I == `SOL_OP_WR_STATUS2 || BYTE_I == `SOL_OP_WR_SEC)
        |=> CMD_BLOCKED_O) else $error("write in OTP mode");
    c_lock: cover property (CUST_LOCK_PGM_O);
    c_otp_wr: cover property (OTP_PROG_EN_O);
    c_refuse: cover property (CMD_BLOCKED_O);
endmodule // sol_otp_lock_chk
bind sol_otp_lock sol_otp_lock_chk chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
    .BYTE_VALID_I(BYTE_VALID_I), .CS_RISE_I(CS_RISE_I),
    .ACCEL_HV_I(ACCEL_HV_I), .OTP_MODE_O(OTP_MODE_O),
    .OTP_PROG_EN_O(OTP_PROG_EN_O), .ARRAY_PROG_EN_O(ARRAY_PROG_EN_O),
    .CMD_BLOCKED_O(CMD_BLOCKED_O), .CUST_LOCK_PGM_O(CUST_LOCK_PGM_O),
    .BYTE_I(BYTE_I), .SEC_REG_O(SEC_REG_O), .PROG_ADDR_I(PROG_ADDR_I));

/* File: tb/sol_otp_lock_tb_top.sv */
// Bench: host model drives the lock block; integer model predicts.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "sol_otp_regs.vh"
module sol_otp_lock_tb_top;
    reg         clk = 0, rst_b = 0, hv = 0, fac = 0, cnv = 0;
    reg  [2:0]  e;
    reg  [55:0] ops = {`SOL_OP_EXIT_OTP, `SOL_OP_ENTER_OTP, `SOL_OP_WR_SEC,
        `SOL_OP_WR_STATUS2, `SOL_OP_WR_STATUS1, `SOL_OP_PAGE_PROG,
        `SOL_OP_RD_STATUS1};
    wire        bv, bip, cs, req, mode, oen, aen, sn, blk, pgm;
    wire [7:0]  bt, sec;
    wire [23:0] pa;
    integer     errors = 0, num_checks = 0, m_mode = 0, m_lock = 0, i;
    integer     n_blk = 0, n_pgm = 0, n_oen = 0, n_aen = 0;
    integer     b_blk = 0, b_pgm = 0, b_oen = 0, b_aen = 0;
    initial forever #25 clk = ~clk;
    // Pulses are counted on falling edges, where they have settled;
    // counting rather than flagging also catches a doubled pulse.
    always @(negedge clk) begin
        n_blk <= n_blk + blk;
        n_pgm <= n_pgm + pgm;
        n_oen <= n_oen + oen;
        n_aen <= n_aen + aen;
    end
    sol_host_model host (.clk_i(clk), .bv_o(bv), .bip_o(bip), .cs_o(cs),
        .req_o(req), .byte_o(bt), .addr_o(pa));
    sol_otp_lock uut (.CLK_I(clk), .RST_B_I(rst_b), .BYTE_VALID_I(bv),
        .BYTE_I(bt), .BIT_IN_BYTE_I(bip), .CS_RISE_I(cs), .ACCEL_HV_I(hv),
        .FACTORY_LOCK_I(fac), .CUST_LOCK_NV_I(cnv), .PROG_ADDR_I(pa),
        .PROG_REQ_I(req), .SEC_REG_O(sec), .OTP_MODE_O(mode),
        .OTP_PROG_EN_O(oen), .ARRAY_PROG_EN_O(aen), .SN_FIELD_O(sn),
        .CMD_BLOCKED_O(blk), .CUST_LOCK_PGM_O(pgm));
    task chk(input [7:0] got, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("[ERR] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task cmd(input [7:0] op, input integer n, input [7:0] d, input cut);
        reg b, p;
        begin
            b = hv ? (op != `SOL_OP_RD_STATUS1 && op != `SOL_OP_PAGE_PROG)
                : (m_mode && (op == `SOL_OP_WR_STATUS1
                || op == `SOL_OP_WR_STATUS2 || op == `SOL_OP_WR_SEC));
            p = !b && op == `SOL_OP_WR_SEC && n == 1 && !cut && d[1] &&
                !m_lock;
            if (!b && op == `SOL_OP_ENTER_OTP) m_mode = 1;
            if (!b && op == `SOL_OP_EXIT_OTP) m_mode = 0;
            mark;
            host.frame(op, n, d, cut);
            repeat (3) @(negedge clk);
            m_lock = m_lock | p;
            chk(8'(n_pgm - b_pgm), 8'(p));
            chk(8'(n_blk - b_blk), 8'(b));
            chk(sec, 8'({m_lock[0], fac}));
            chk(8'(mode), 8'(m_mode[0]));
        end
    endtask
    task prg(input [23:0] a);
        begin
            mark;
            host.prog(a);
            e = {m_mode && a <= `SOL_OTP_SN_LAST, m_mode == 0,
                m_mode && !m_lock && !fac && a <= `SOL_OTP_LAST};
            chk(8'(sn), 8'(e[2]));
            chk(8'(n_aen - b_aen), 8'(e[1]));
            chk(8'(n_oen - b_oen), 8'(e[0]));
        end
    endtask
    // Take the pulse counts at a rising edge, clear of their updates
    task mark;
        begin
            @(posedge clk);
            b_blk = n_blk;
            b_pgm = n_pgm;
            b_oen = n_oen;
            b_aen = n_aen;
        end
    endtask
    task conclude;
        begin
            if (errors == 0 && num_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        #200000;
        errors = errors + 1;
        conclude;
    end
    initial begin
        void'($urandom(32'h17e235ef));
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (8) @(negedge clk); // Scaled write delay
        cmd(`SOL_OP_ENTER_OTP, 0, 0, 0);
        prg(24'($urandom % 512));
        prg(24'h00_000F);
        prg(24'h00_0010);
        prg(24'h00_0200);
        for (i = 0; i < 7; i = i + 1) begin
            cmd(ops[8*i +: 8], 1, 2, 0);
        end
        prg(24'h00_0004);
        cmd(`SOL_OP_WR_SEC, 1, 8'h02, 1);
        cmd(`SOL_OP_WR_SEC, 0, 8'h02, 0);
        cmd(`SOL_OP_WR_SEC, 2, 8'h02, 0);
        cmd(`SOL_OP_WR_SEC, 1, 8'($urandom) & 8'hFD, 0);
        cmd(`SOL_OP_WR_SEC, 1, 8'($urandom) | 8'h02, 0);
        cmd(`SOL_OP_ENTER_OTP, 0, 0, 0);
        prg(24'h00_0020);
        hv = 1'b1;
        repeat (100) @(negedge clk); // Settle time
        for (i = 0; i < 7; i = i + 1) begin
            cmd(ops[8*i +: 8], 0, 0, 0);
        end
        prg(24'h00_000C); // Word-aligned start
        hv = 1'b0;
        repeat (100) @(negedge clk);
        {rst_b, fac, cnv} = 3'b011;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        m_mode = 0;
        m_lock = cnv;
        repeat (8) @(negedge clk);
        cmd(`SOL_OP_ENTER_OTP, 0, 0, 0);
        prg(24'h00_0008);
        conclude;
    end
endmodule // sol_otp_lock_tb_top
